// ===== rtl/pwf_framer.sv
// Plasma word framer: builds the 186-word sequences and shifts them out NRZ.
// Assumes bit_strobe/demand/frame_mark are single-cycle pulses from the data processor.
//
// Overview of operation
// - Words leave as a serial NRZ bit stream toward the data subsystem.
// - At most four words are handed over after each frame mark, besides one taken in the mark cycle itself.
// - A cycle is 16 sequences of 186 ten-bit words in fixed order.
// - The two leading bits of each word identify its type in the sequence.
// - Word 184 (zero based) of a sequence carries the sequence number in its low bits.
// - A sequence holds 112 positive, 56 negative, 16 calibration/operation and 2 ident words.
// - Internal calibration levels are injected through the normal measurement path.
// - Data from each of the seven cups and from all cups combined is sent.
// - Grid polarity is positive then negative, and grid magnitude steps across the sequence.
// - A word is handed over only on a demand from the data subsystem.
`timescale 1ns/1ns
`default_nettype none
module pwf_framer
  import pwf_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Data processor timing
  input wire logic frame_mark_in,
  input wire logic demand_in,
  input wire logic bit_strobe_in,
  // Measurement chain
  input wire logic [PAY_BITS-1:0] meas_data_in,
  output var pwf_sel_s sel_out,
  // Serial output
  output logic ser_data_out,
  output logic busy_out,
  output logic word_done_out
);
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } pwf_state_e;

  pwf_state_e state_r;
  logic [7:0] word_r;
  logic [3:0] seq_r;
  logic [7:0] cyc_r;
  logic [3:0] bit_r;
  logic [2:0] frame_cnt_r;
  logic [WORD_BITS-1:0] shift_r;
  logic ser_r;
  logic done_r;
  pwf_sel_s sel_r;
  logic take;
  logic last_bit;
  pwf_word_s word_nxt;
  logic [7:0] grp_off;

  // Word type from position
  function automatic pwf_id_e word_kind(input logic [7:0] w);
    if (w < NEG_FIRST) begin
      return ID_POS;
    end else if (w < CAL_FIRST) begin
      return ID_NEG;
    end else if (w < SEQ_ID_WORD) begin
      return ID_CAL;
    end else begin
      return ID_IDENT;
    end
  endfunction

  // Offset of a word within its group
  function automatic logic [7:0] group_off(input logic [7:0] w);
    case (word_kind(w))
      ID_POS: group_off = w - POS_FIRST;
      ID_NEG: group_off = w - NEG_FIRST;
      ID_CAL: group_off = w - CAL_FIRST;
      default: group_off = 8'h00;
    endcase
  endfunction

  // Bits of a call result cannot be selected directly
  assign grp_off = group_off(word_r);

  // Demand refused once four words are taken after the frame mark
  assign take = (state_r == ST_IDLE) && demand_in && (frame_cnt_r != FRAME_LAST);
  assign last_bit = (state_r == ST_SHIFT) && bit_strobe_in && (bit_r == BIT_LAST);

  always_comb begin
    word_nxt.id = word_kind(word_r);
    word_nxt.payload = meas_data_in;
    if (word_r == SEQ_ID_WORD) begin
      word_nxt.payload = {4'h0, seq_r};
    end else if (word_r == CYC_ID_WORD) begin
      word_nxt.payload = cyc_r;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (last_bit) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_r <= '0;
      bit_r <= 4'h0;
      ser_r <= 1'b0;
    end else if (take) begin
      shift_r <= {word_nxt.id, word_nxt.payload};
      bit_r <= 4'h0;
      ser_r <= word_nxt.id[1];
    end else if (state_r == ST_SHIFT && bit_strobe_in) begin
      shift_r <= {shift_r[WORD_BITS-2:0], 1'b0};
      bit_r <= bit_r + 4'h1;
      ser_r <= last_bit ? 1'b0 : shift_r[WORD_BITS-2];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_cnt_r <= 3'h0;
    end else if (frame_mark_in) begin
      frame_cnt_r <= 3'h0;
    end else if (take) begin
      frame_cnt_r <= frame_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_r <= WORD_RST;
      seq_r <= SEQ_RST;
      cyc_r <= CYC_RST;
    end else if (last_bit) begin
      if (word_r == LAST_WORD) begin
        word_r <= WORD_RST;
        seq_r <= seq_r + 4'h1;
        if (seq_r == LAST_SEQ) begin
          cyc_r <= cyc_r + 8'h01;
        end
      end else begin
        word_r <= word_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_r <= 1'b0;
    end else begin
      done_r <= last_bit;
    end
  end

  // Cups 0..6 then combined channel 7
  // Calibration injected in first cal words
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_r <= '0;
    end else begin
      sel_r.grid_neg <= (word_kind(word_r) == ID_NEG);
      sel_r.cup_sel <= grp_off[2:0];
      sel_r.grid_step <= grp_off[6:3];
      sel_r.cal_inject <= (word_kind(word_r) == ID_CAL) && (word_r < OPS_FIRST);
      sel_r.ops_sel <= (word_kind(word_r) == ID_CAL) && (word_r >= OPS_FIRST);
    end
  end

  assign ser_data_out = ser_r;
  assign busy_out = (state_r == ST_SHIFT);
  assign word_done_out = done_r;
  assign sel_out = sel_r;

  sequence s_word_taken;
    take ##1 busy_out;
  endsequence

  sequence s_word_ends;
    last_bit ##1 (!busy_out && word_done_out);
  endsequence

  chk_demand_starts_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take |-> s_word_taken)
    else $error("demand did not start a word");

  chk_no_start_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!busy_out && !demand_in) |=> !busy_out)
    else $error("word started without demand");

  chk_frame_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (frame_cnt_r == FRAME_LAST && demand_in && !busy_out) |=> !busy_out)
    else $error("fifth word in a frame was started");

  chk_word_end_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    last_bit |-> s_word_ends)
    else $error("word did not end after ten bits");

  chk_first_bit_id: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take |=> (ser_data_out == $past(word_nxt.id[1])))
    else $error("first bit is not identifier msb");

  chk_word_wrap_seq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (last_bit && word_r == LAST_WORD) |=> (word_r == WORD_RST && seq_r == $past(seq_r) + 4'h1))
    else $error("sequence did not advance on wrap");

  chk_word_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    word_r <= LAST_WORD)
    else $error("word counter out of range");

  chk_seq_number_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (take && word_r == SEQ_ID_WORD) |=> (shift_r[3:0] == $past(seq_r)))
    else $error("sequence number missing in ident word");

  chk_neg_polarity: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_r >= NEG_FIRST && word_r < CAL_FIRST && $stable(word_r)) |=> sel_out.grid_neg)
    else $error("grid not negative in negative group");

  chk_cal_inject: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_r >= CAL_FIRST && word_r < OPS_FIRST) |=> sel_out.cal_inject)
    else $error("calibration not injected");
endmodule
`default_nettype wire

// ===== pkg/pwf_pkg.sv
// Plasma word framer: shared constants, types and word map.
// Assumes a single 25 MHz clock domain; link strobes arrive synchronous.
package pwf_pkg;
  localparam int unsigned WORD_BITS = 10;
  localparam int unsigned ID_BITS = 2;
  localparam int unsigned PAY_BITS = WORD_BITS - ID_BITS;
  localparam int unsigned SEQ_WORDS = 186;
  localparam int unsigned CYC_SEQS = 16;
  localparam int unsigned FRAME_WORDS = 4;
  localparam int unsigned NUM_CHAN = 8;
  // Word map within one sequence (zero based)
  localparam logic [7:0] POS_FIRST = 8'h00;
  localparam logic [7:0] NEG_FIRST = 8'h70;
  localparam logic [7:0] CAL_FIRST = 8'hA8;
  localparam logic [7:0] OPS_FIRST = 8'hB0;
  localparam logic [7:0] SEQ_ID_WORD = 8'hB8;
  localparam logic [7:0] CYC_ID_WORD = 8'hB9;
  localparam logic [7:0] LAST_WORD = 8'hB9;
  localparam logic [3:0] LAST_SEQ = 4'hF;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [2:0] FRAME_LAST = 3'h4;
  // Reset values
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic [3:0] SEQ_RST = 4'h0;
  localparam logic [7:0] CYC_RST = 8'h00;

  typedef enum logic [1:0] {
    ID_POS = 2'b00,
    ID_NEG = 2'b01,
    ID_CAL = 2'b10,
    ID_IDENT = 2'b11
  } pwf_id_e;

  typedef struct packed {
    pwf_id_e id;
    logic [PAY_BITS-1:0] payload;
  } pwf_word_s;

  typedef struct packed {
    logic grid_neg;
    logic [3:0] grid_step;
    logic [2:0] cup_sel;
    logic cal_inject;
    logic ops_sel;
  } pwf_sel_s;
endpackage

// ===== tb/pwf_dp_model.sv
// Data processor stand-in: frame marks, demands and bit strobes.
// Assumes the framer shifts MSB first, one bit per strobe.
`timescale 1ns/1ns
`default_nettype none
module pwf_dp_model (
  input wire logic clk_in,
  input wire logic ser_in,
  output logic frame_mark_out,
  output logic demand_out,
  output logic strobe_out
);
  initial begin
    frame_mark_out = 1'b0;
    demand_out = 1'b0;
    strobe_out = 1'b0;
  end
  task automatic pulse(input logic dem);
    @(posedge clk_in) begin
      if (dem) demand_out <= 1'b1;
      else frame_mark_out <= 1'b1;
    end
    @(posedge clk_in) begin
      demand_out <= 1'b0;
      frame_mark_out <= 1'b0;
    end
  endtask
  task automatic xfer(input int gap, output logic [9:0] w);
    pulse(1'b1);
    for (int k = 9; k >= 0; k--) begin
      repeat (gap) @(posedge clk_in);
      #1 w[k] = ser_in;
      @(posedge clk_in) strobe_out <= 1'b1;
      @(posedge clk_in) strobe_out <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/pwf_framer_tb_top.sv
// Testbench for the plasma word framer: one full cycle plus wrap.
// Assumes the data processor model paces every word.
`timescale 1ns/1ns
`default_nettype none
module pwf_framer_tb_top;
  import pwf_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [PAY_BITS-1:0] meas;
  pwf_sel_s sel;
  logic ser, busy, done, fm, dem, stb;
  logic [9:0] got;
  int num_errors = 0;
  int checks = 0;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
  always #20 clk_in = ~clk_in;
  pwf_framer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .frame_mark_in(fm),
    .demand_in(dem), .bit_strobe_in(stb), .meas_data_in(meas), .sel_out(sel),
    .ser_data_out(ser), .busy_out(busy), .word_done_out(done));
  pwf_dp_model dp (.clk_in(clk_in), .ser_in(ser), .frame_mark_out(fm),
    .demand_out(dem), .strobe_out(stb));
  function automatic logic [9:0] exp_word(int w, int s, int c, logic [7:0] m);
    if (w < 112) return {2'b00, m};
    if (w < 168) return {2'b01, m};
    if (w < 184) return {2'b10, m};
    if (w == 184) return {2'b11, 4'h0, s[3:0]};
    return {2'b11, c[7:0]};
  endfunction
  function automatic pwf_sel_s exp_sel(int w);
    pwf_sel_s e;
    int o;
    o = (w < 112) ? w : w - 112;
    e = '0;
    e.grid_neg = (w >= 112);
    e.cup_sel = o[2:0];
    e.grid_step = o[6:3];
    return e;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic run_word(int w, int s, int c);
    @(posedge clk_in) meas <= PAY_BITS'($urandom);
    #1;
    if (w < 168) `CHK(sel, exp_sel(w))
    else `CHK({sel.cal_inject, sel.ops_sel}, {w < 176, w >= 176 && w < 184})
    dp.xfer(($urandom % 3 == 0) ? 1 : 0, got);
    `CHK(got, exp_word(w, s, c, meas))
    // Line returns low once the word is out
    #1 `CHK({done, busy, ser}, 3'b100)
  endtask
  initial begin
    meas = '0;
    void'($urandom(32'hB8FB9AB1));
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    #1 `CHK({ser, busy, done, sel}, 12'h000)
    $display("test reset done");
    for (int n = 0; n < 16 * 186 + 4; n++) begin
      if (n % 4 == 0) dp.pulse(1'b0);
      run_word(n % 186, (n / 186) % 16, n / 2976);
    end
    $display("test cycle and wrap done");
    // Fifth demand in one frame must be ignored
    dp.pulse(1'b1);
    repeat (3) @(posedge clk_in);
    #1 `CHK(busy, 1'b0)
    dp.pulse(1'b0);
    run_word(4, 0, 1);
    $display("test frame limit done");
    print_verdict();
  end
  initial begin
    #4000000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
